//--- rtl/swsc_axil.sv
// AXI4-Lite slave front end: write and read channel handshakes
`timescale 1ns/100ps
module swsc_axil (
  input  wire logic        aclk,     // system clock
  input  wire logic        aresetn,  // sync reset, active low
  input  wire logic        awvalid,  // write address valid
  output logic             awready,  // write address ready
  input  wire logic [3:0]  awaddr,   // write address
  input  wire logic        wvalid,   // write data valid
  output logic             wready,   // write data ready
  input  wire logic [31:0] wdata,    // write data
  input  wire logic [3:0]  wstrb,    // write strobes
  output logic             bvalid,   // write response valid
  input  wire logic        bready,   // write response ready
  output logic [1:0]       bresp,    // write response
  input  wire logic        arvalid,  // read address valid
  output logic             arready,  // read address ready
  input  wire logic [3:0]  araddr,   // read address
  output logic             rvalid,   // read data valid
  input  wire logic        rready,   // read data ready
  output logic [31:0]      rdata,    // read data
  output logic [1:0]       rresp,    // read response
  output logic             wr_go,    // one-cycle write strobe
  output logic [3:0]       wr_addr,  // write address
  output logic [31:0]      wr_data,  // write data
  output logic [3:0]       wr_strb,  // write strobes
  input  wire logic        wr_err,   // write address unmapped
  output logic [3:0]       rd_addr,  // read address, combinational
  output logic             rd_go,    // read taken this cycle
  input  wire logic [31:0] rd_val,   // read value for rd_addr
  input  wire logic        rd_err    // read address unmapped
);
  logic have_aw;
  logic have_w;

  assign rd_addr = araddr;
  assign rd_go   = arvalid && arready;

  // readies come from flops: low from their own handshake until the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
      wready  <= 1'b1;
    end else begin
      if (awvalid && awready) awready <= 1'b0;
      if (wvalid && wready) wready <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) arready <= 1'b1;
    else if (arvalid && arready) arready <= 1'b0;
    else if (rvalid && rready) arready <= 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      have_aw <= 1'b0;
      have_w  <= 1'b0;
      wr_addr <= 4'h0;
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        have_aw <= 1'b1;
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        have_w  <= 1'b1;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (wr_go) begin
        have_aw <= 1'b0;
        have_w  <= 1'b0;
      end
    end
  end

  assign wr_go = have_aw && have_w && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= swsc_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp  <= wr_err ? swsc_pkg::RESP_SLVERR : swsc_pkg::RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= swsc_pkg::RESP_OKAY;
    end else if (rd_go) begin
      rvalid <= 1'b1;
      rdata  <= rd_val;
      rresp  <= rd_err ? swsc_pkg::RESP_SLVERR : swsc_pkg::RESP_OKAY;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule

//--- rtl/swsc_detect.sv
// level/edge detector for one wake source
`timescale 1ns/100ps
module swsc_detect (
  input  wire logic       aclk,      // system clock
  input  wire logic       aresetn,   // sync reset, active low
  input  wire logic       src_in,    // wake source level
  input  wire logic [2:0] mode,      // detection mode
  input  wire logic       enable,    // wake enable
  input  wire logic       clear,     // clear pulse from clear code
  output logic            req,       // standby clear request
  output logic [1:0]      seen       // activity seen
);
  logic prev;
  logic rise;
  logic fall;
  logic hit;

  assign rise = src_in & ~prev;
  assign fall = ~src_in & prev;

  always_comb begin
    case (mode)
      swsc_pkg::MODE_LOW:  hit = ~src_in;
      swsc_pkg::MODE_HIGH: hit = src_in;
      swsc_pkg::MODE_FALL: hit = fall;
      swsc_pkg::MODE_RISE: hit = rise;
      swsc_pkg::MODE_BOTH: hit = rise | fall;
      default:             hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) prev <= 1'b0;
    else prev <= src_in;
  end

  // request holds until cleared; a new hit in the clear cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) req <= 1'b0;
    else if (enable && hit) req <= 1'b1;
    else if (clear) req <= 1'b0;
  end

  // only both-edge mode records which edge released standby
  always_ff @(posedge aclk) begin
    if (!aresetn) seen <= swsc_pkg::SEEN_NONE;
    else if (enable && mode == swsc_pkg::MODE_BOTH && (rise || fall))
      seen <= seen | (rise ? swsc_pkg::SEEN_RISE : swsc_pkg::SEEN_FALL);
    else if (clear) seen <= swsc_pkg::SEEN_NONE;
  end

  req_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clear && !(enable && hit)) |=> !req) else $error("request not cleared");
  seen_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode != swsc_pkg::MODE_BOTH && $stable(mode) && seen == 2'h0) |=> seen == 2'h0)
    else $error("seen changed outside both-edge mode");
endmodule

//--- rtl/swsc_pkg.sv
// constants and types for the standby wake source bank
package swsc_pkg;
  localparam int          ADDR_W        = 4;
  localparam logic [3:0]  OFF_MODE_BANK = 4'h0;
  localparam logic [3:0]  OFF_CLEAR     = 4'h4;
  localparam logic [3:0]  OFF_IRQ_STAT  = 4'h8;
  localparam logic [3:0]  OFF_IRQ_MASK  = 4'hC;
  localparam int          NSRC          = 4;
  localparam int          MODE_LSB      = 4;
  localparam int          SEEN_LSB      = 2;
  localparam int          EN_LSB        = 0;
  localparam int          LANE_W        = 8;
  // reset value of each mode field: falling edge (bit 1 of the field set)
  localparam logic [2:0]  MODE_RESET    = 3'h2;
  localparam logic [2:0]  MODE_LOW      = 3'h0;
  localparam logic [2:0]  MODE_HIGH     = 3'h1;
  localparam logic [2:0]  MODE_FALL     = 3'h2;
  localparam logic [2:0]  MODE_RISE     = 3'h3;
  localparam logic [2:0]  MODE_BOTH     = 3'h4;
  localparam logic [1:0]  SEEN_NONE     = 2'h0;
  localparam logic [1:0]  SEEN_RISE     = 2'h1;
  localparam logic [1:0]  SEEN_FALL     = 2'h2;
  localparam logic [1:0]  SEEN_BOTH     = 2'h3;
  // clear codes; source index = code - CLR_BASE
  localparam logic [4:0]  CLR_BASE      = 5'h08;
  localparam logic [4:0]  CLR_LAST      = 5'h0B;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  typedef enum logic [1:0] {SWSC_IDLE = 2'b00, SWSC_RESP = 2'b01} swsc_state_t;
endpackage

//--- rtl/swsc_top.sv
// wake source mode bank C: four standby release sources behind AXI4-Lite
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/100ps
// Function
// - Bits 27-26 report the second remote receiver activity: none, rising, falling, both.
// - Bits 24, 16, 8 and 0 enable each source; 0 blocks and 1 passes its standby clear request.
// - Bits 22-20 select interrupt seven's low, high, falling, rising or both-edge detection; 101-111 are forbidden.
// - Bits 19-18 report interrupt seven's activity with the same encoding.
// - Bits 14-12 select interrupt six's detection in the same five codes, enable at bit 8.
// - Bits 11-10 report interrupt six's activity.
// - Bits 3-2 report the clock source's activity.
// - An activity field only gains bits while its mode is both edges 100; a clear code empties it in any mode.
// - A clear code for a source also resets its activity field to 00; an edge in the same cycle wins and is ORed into the old field.
// - Clear codes 0_1000 to 0_1011 select clock, six, seven and second receiver; 0_1100 up are forbidden.
module swsc_top (
  input  wire logic        aclk,                    // 100 MHz system clock
  input  wire logic        aresetn,                 // sync reset, active low
  input  wire logic        awvalid,                 // axi write address valid
  output logic             awready,                 // axi write address ready
  input  wire logic [3:0]  awaddr,                  // axi write address
  input  wire logic [2:0]  awprot,                  // axi protection, unused
  input  wire logic        wvalid,                  // axi write data valid
  output logic             wready,                  // axi write data ready
  input  wire logic [31:0] wdata,                   // axi write data
  input  wire logic [3:0]  wstrb,                   // axi write strobes
  output logic             bvalid,                  // axi write response valid
  input  wire logic        bready,                  // axi write response ready
  output logic [1:0]       bresp,                   // axi write response
  input  wire logic        arvalid,                 // axi read address valid
  output logic             arready,                 // axi read address ready
  input  wire logic [3:0]  araddr,                  // axi read address
  input  wire logic [2:0]  arprot,                  // axi protection, unused
  output logic             rvalid,                  // axi read data valid
  input  wire logic        rready,                  // axi read data ready
  output logic [31:0]      rdata,                   // axi read data
  output logic [1:0]       rresp,                   // axi read response
  input  wire logic        rtc_event,               // clock wake source
  input  wire logic        ext_irq_six,             // external interrupt six
  input  wire logic        ext_irq_seven,           // external interrupt seven
  input  wire logic        remote_receiver_b_event, // second remote receiver
  output logic [3:0]       standby_clear_req,       // per-source requests
  output logic             irq                      // level interrupt
);
  localparam int N = swsc_pkg::NSRC;

  logic [2:0]  mode [N];
  logic [N-1:0] en;
  logic [N-1:0] req;
  logic [1:0]  seen [N];
  logic [N-1:0] clr;
  logic [N-1:0] src;
  logic [N-1:0] req_d;
  logic [N-1:0] irq_stat;
  logic [N-1:0] irq_mask;
  logic        wr_go;
  logic [3:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_err;
  logic [3:0]  rd_addr;
  logic        rd_go;
  logic [31:0] rd_val;
  logic        rd_err;
  logic [31:0] bank_val;
  logic        bank_wr;
  logic        clear_wr;
  logic        stat_wr;
  logic        mask_wr;

  // lane i holds source i: rtc, six, seven, remote b
  assign src = {remote_receiver_b_event, ext_irq_seven, ext_irq_six, rtc_event};

  function automatic logic mapped(input logic [3:0] a);
    mapped = (a == swsc_pkg::OFF_MODE_BANK) || (a == swsc_pkg::OFF_CLEAR)
          || (a == swsc_pkg::OFF_IRQ_STAT) || (a == swsc_pkg::OFF_IRQ_MASK);
  endfunction

  // bit position of each field inside a source's byte lane
  function automatic int mode_pos(input int lane);
    mode_pos = lane * swsc_pkg::LANE_W + swsc_pkg::MODE_LSB;
  endfunction

  function automatic int seen_pos(input int lane);
    seen_pos = lane * swsc_pkg::LANE_W + swsc_pkg::SEEN_LSB;
  endfunction

  function automatic int en_pos(input int lane);
    en_pos = lane * swsc_pkg::LANE_W + swsc_pkg::EN_LSB;
  endfunction

  swsc_axil u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awvalid (awvalid),
    .awready (awready),
    .awaddr  (awaddr),
    .wvalid  (wvalid),
    .wready  (wready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .bvalid  (bvalid),
    .bready  (bready),
    .bresp   (bresp),
    .arvalid (arvalid),
    .arready (arready),
    .araddr  (araddr),
    .rvalid  (rvalid),
    .rready  (rready),
    .rdata   (rdata),
    .rresp   (rresp),
    .wr_go   (wr_go),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_err  (wr_err),
    .rd_addr (rd_addr),
    .rd_go   (rd_go),
    .rd_val  (rd_val),
    .rd_err  (rd_err)
  );

  assign wr_err = !mapped(wr_addr);
  assign rd_err = !mapped(rd_addr);

  // one write strobe per register; the clear code and the interrupt
  // registers sit in byte lane 0 only
  assign bank_wr  = wr_go && wr_addr == swsc_pkg::OFF_MODE_BANK;
  assign clear_wr = wr_go && wr_addr == swsc_pkg::OFF_CLEAR && wr_strb[0];
  assign stat_wr  = wr_go && wr_addr == swsc_pkg::OFF_IRQ_STAT && wr_strb[0];
  assign mask_wr  = wr_go && wr_addr == swsc_pkg::OFF_IRQ_MASK && wr_strb[0];

  // mode and enable fields, one byte lane each; modes are not checked for
  // forbidden codes, which simply never match
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < N; i++) begin
        mode[i] <= swsc_pkg::MODE_RESET;
        en[i]   <= 1'b0;
      end
    end else if (bank_wr) begin
      for (int i = 0; i < N; i++) begin
        if (wr_strb[i]) begin
          mode[i] <= wr_data[mode_pos(i) +: 3];
          en[i]   <= wr_data[en_pos(i)];
        end
      end
    end
  end

  // clear code decode; codes outside the four sources do nothing here
  always_comb begin
    clr = '0;
    if (clear_wr && wr_data[4:0] >= swsc_pkg::CLR_BASE
        && wr_data[4:0] <= swsc_pkg::CLR_LAST)
      clr[2'(wr_data[4:0] - swsc_pkg::CLR_BASE)] = 1'b1;
  end

  for (genvar g = 0; g < N; g++) begin : g_src
    swsc_detect u_det (
      .aclk    (aclk),
      .aresetn (aresetn),
      .src_in  (src[g]),
      .mode    (mode[g]),
      .enable  (en[g]),
      .clear   (clr[g]),
      .req     (req[g]),
      .seen    (seen[g])
    );
  end

  // reserved bits (31,23,15,7 and 25,17,9,1) read zero
  always_comb begin
    bank_val = '0;
    for (int i = 0; i < N; i++) begin
      bank_val[mode_pos(i) +: 3] = mode[i];
      bank_val[seen_pos(i) +: 2] = seen[i];
      bank_val[en_pos(i)]        = en[i];
    end
  end

  always_comb begin
    case (rd_addr)
      swsc_pkg::OFF_MODE_BANK: rd_val = bank_val;
      swsc_pkg::OFF_IRQ_STAT:  rd_val = {28'h0, irq_stat};
      swsc_pkg::OFF_IRQ_MASK:  rd_val = {28'h0, irq_mask};
      default:                 rd_val = 32'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) standby_clear_req <= '0;
    else standby_clear_req <= req;
  end

  // interrupt status: rising request, write one to clear, set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) req_d <= '0;
    else req_d <= req;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) irq_stat <= '0;
    else if (stat_wr)
      irq_stat <= (irq_stat & ~wr_data[N-1:0]) | (req & ~req_d);
    else
      irq_stat <= irq_stat | (req & ~req_d);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) irq_mask <= '0;
    else if (mask_wr)
      irq_mask <= wr_data[N-1:0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) irq <= 1'b0;
    else irq <= |(irq_stat & irq_mask);
  end

  // source side: enables, request path and activity fields
  disabled_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!en[0] && !req[0]) |=> !req[0]) else $error("disabled source raised request");

  remote_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!en[3] && !req[3]) |=> !req[3]) else $error("disabled remote source raised request");

  req_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
    req[1] |=> standby_clear_req[1]) else $error("request output lag wrong");

  req_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !req[3] |=> !standby_clear_req[3]) else $error("request output without request");

  // a clear with no edge in the same cycle must empty the field
  clear_seen_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clr[2] && $stable(src[2])) |=> seen[2] == swsc_pkg::SEEN_NONE) else $error("clear left activity");

  // register side: field writes, clear codes and read-back
  mode_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (bank_wr && wr_strb[1]) |=> mode[1] == $past(wr_data[mode_pos(1) +: 3]))
    else $error("mode field write lost");

  mode_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !bank_wr |=> mode[2] == $past(mode[2])) else $error("mode field changed without a write");

  en_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (bank_wr && wr_strb[3]) |=> en[3] == $past(wr_data[en_pos(3)]))
    else $error("enable bit write lost");

  code_hit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clear_wr && wr_data[4:0] == swsc_pkg::CLR_BASE) |-> $onehot(clr) && clr[0])
    else $error("clock clear code missed");

  bad_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clear_wr && wr_data[4:0] > swsc_pkg::CLR_LAST) |-> clr == '0)
    else $error("prohibited clear code acted");

  reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_go && rd_addr == swsc_pkg::OFF_MODE_BANK |=> rdata[31] == 1'b0 && rdata[25] == 1'b0)
    else $error("reserved bit not zero");

  reserved_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_go && rd_addr == swsc_pkg::OFF_MODE_BANK |=> rdata[23] == 1'b0 && rdata[15] == 1'b0 && rdata[7] == 1'b0)
    else $error("reserved low bit not zero");

  seen_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_go && rd_addr == swsc_pkg::OFF_MODE_BANK |=> rdata[27:26] == $past(seen[3]))
    else $error("activity field read wrong");

  seen_rtc_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_go && rd_addr == swsc_pkg::OFF_MODE_BANK |=> rdata[seen_pos(0) +: 2] == $past(seen[0]))
    else $error("clock activity field read wrong");

  seen_six_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_go && rd_addr == swsc_pkg::OFF_MODE_BANK |=> rdata[seen_pos(1) +: 2] == $past(seen[1]))
    else $error("six activity field read wrong");

  seen_seven_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_go && rd_addr == swsc_pkg::OFF_MODE_BANK |=> rdata[seen_pos(2) +: 2] == $past(seen[2]))
    else $error("seven activity field read wrong");

  rd_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_go && rd_err) |=> rresp == swsc_pkg::RESP_SLVERR) else $error("unmapped read not refused");

  // interrupt side: sticky status, set wins, level output
  stat_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (req[2] && !req_d[2]) |=> irq_stat[2]) else $error("status missed a request");

  stat_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (stat_wr && wr_data[1] && !(req[1] && !req_d[1])) |=> !irq_stat[1])
    else $error("status bit not cleared");

  mask_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    mask_wr |=> irq_mask == $past(wr_data[N-1:0])) else $error("mask write lost");

  irq_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (|(irq_stat & irq_mask)) |=> irq) else $error("interrupt missing");

  irq_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !(|(irq_stat & irq_mask)) |=> !irq) else $error("interrupt without cause");
endmodule

//--- tb/standby_wake_source_config_c_bench.sv
// self-checking bench for the wake source bank
`timescale 1ns/100ps
module standby_wake_source_config_c_bench;
  logic             aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0]       awaddr, araddr, wstrb;
  logic [31:0]      wdata, rd;
  logic [1:0]       rsp;
  wire logic        awready, wready, bvalid, arready, rvalid, irq;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [3:0]  srcs, reqs;
  wire logic [4:0]  obs;
  int               fail_count, checked;

  assign obs = {irq, reqs};
  always #5 aclk = ~aclk;

  swsc_src_model src_u (.aclk(aclk), .srcs(srcs));
  swsc_top dut_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .rtc_event(srcs[0]),
    .ext_irq_six(srcs[1]), .ext_irq_seven(srcs[2]), .remote_receiver_b_event(srcs[3]),
    .standby_clear_req(reqs), .irq(irq));

  task wrap_up;
    $display("counts: %0d checked, %0d failed", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task hang(input string what);
    fail_count++;
    $display("[FAIL] %s expected done seen timeout", what);
    wrap_up();
  endtask

  // address and data offered together, each released once taken
  task axw(input logic [3:0] a, input logic [31:0] d);
    int   n;
    logic ah, wh, bh;
    n = 0;
    bh = 1'b0;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    while (!bh) begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      rsp = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      n++;
      if (n > 50) hang("write");
    end
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task axr(input logic [3:0] a);
    int   n;
    logic ah, rh;
    n = 0;
    rh = 1'b0;
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    while (!rh) begin
      @(negedge aclk);
      ah = arvalid && arready;
      rh = rvalid;
      rd = rdata;
      rsp = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
      n++;
      if (n > 50) hang("read");
    end
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // waits for a request bit (0-3) or irq (4) to reach a level
  task wait_obs(input int i, input logic want);
    int n;
    n = 0;
    while (obs[i] !== want && n < 20) begin
      @(negedge aclk);
      n++;
    end
    if (obs[i] !== want) hang("flag");
    @(posedge aclk);
  endtask

  task t_reset;
    axr(swsc_pkg::OFF_MODE_BANK);
    chk("bank reset", 32'h20202020, rd);
    axr(swsc_pkg::OFF_CLEAR);
    chk("clear reads", 32'h0, rd);
    axr(4'h6);
    chk("unmapped resp", {30'h0, swsc_pkg::RESP_SLVERR}, {30'h0, rsp});
    $display("test reset done");
  endtask

  task t_modes;
    // modes alone first; ones aimed at read-only and reserved bits
    axw(swsc_pkg::OFF_MODE_BANK, 32'hBECE9EAE);
    chk("write resp", 32'h0, {30'h0, rsp});
    axr(swsc_pkg::OFF_MODE_BANK);
    chk("mode readback", 32'h30401020, rd);
    src_u.drive(0, 1'b1, 0);
    src_u.drive(0, 1'b0, 3);
    repeat (4) @(posedge aclk);
    chk("disabled req", 32'h0, {28'h0, reqs});
    $display("test modes done");
  endtask

  task t_enable;
    axw(swsc_pkg::OFF_MODE_BANK, 32'h31411121);
    src_u.drive(1, 1'b1, 0);
    wait_obs(1, 1'b1);
    chk("level req", 32'h2, {28'h0, reqs});
    chk("irq masked", 32'h0, {31'h0, irq});
    axw(swsc_pkg::OFF_IRQ_MASK, 32'hF);
    wait_obs(4, 1'b1);
    chk("irq on", 32'h1, {31'h0, irq});
    src_u.drive(1, 1'b0, 0);
    axw(swsc_pkg::OFF_IRQ_STAT, 32'hF);
    wait_obs(4, 1'b0);
    chk("irq off", 32'h0, {31'h0, irq});
    chk("req sticky", 32'h2, {28'h0, reqs});
    axw(swsc_pkg::OFF_CLEAR, 32'h09);
    wait_obs(1, 1'b0);
    chk("clear six", 32'h0, {28'h0, reqs});
    $display("test enable done");
  endtask

  task t_both;
    src_u.drive(2, 1'b1, 0);
    src_u.drive(2, 1'b0, 3);
    wait_obs(2, 1'b1);
    repeat (4) @(posedge aclk);
    axr(swsc_pkg::OFF_MODE_BANK);
    chk("both seen", 32'h314D1121, rd);
    axw(swsc_pkg::OFF_CLEAR, 32'h0D);
    chk("bad code", 32'h4, {28'h0, reqs});
    axw(swsc_pkg::OFF_CLEAR, 32'h0A);
    wait_obs(2, 1'b0);
    axr(swsc_pkg::OFF_MODE_BANK);
    chk("seen cleared", 32'h31411121, rd);
    axw(swsc_pkg::OFF_IRQ_STAT, 32'hF);
    $display("test both edges done");
  endtask

  task t_edges;
    src_u.drive(3, 1'b1, 0);
    wait_obs(3, 1'b1);
    src_u.drive(0, 1'b1, 0);
    src_u.drive(0, 1'b0, 2);
    wait_obs(0, 1'b1);
    chk("edge reqs", 32'h9, {28'h0, reqs});
    axr(swsc_pkg::OFF_MODE_BANK);
    chk("seen idle", 32'h31411121, rd);
    axw(swsc_pkg::OFF_CLEAR, 32'h0B);
    axw(swsc_pkg::OFF_CLEAR, 32'h08);
    wait_obs(0, 1'b0);
    chk("all cleared", 32'h0, {28'h0, reqs});
    $display("test edges done");
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    wstrb = 4'hF;
    fail_count = 0;
    checked = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_modes();
    t_enable();
    t_both();
    t_edges();
    wrap_up();
  end
endmodule

//--- tb/swsc_src_model.sv
// far-side model: levels of the four wake sources
`timescale 1ns/100ps
module swsc_src_model (
  input  wire logic       aclk, // system clock
  output logic      [3:0] srcs  // rtc, six, seven, remote b
);
  initial srcs = 4'h0;
  // a source moves only just after a rising edge; dly gives prompt or slow activity
  task drive(input int idx, input logic val, input int dly);
    repeat (dly) @(posedge aclk);
    srcs[idx] <= val;
  endtask
endmodule
